// ===== include/sdram_burst_cfg.svh
/*
 * Constants of the burst and precharge block: register offsets, field
 * positions, reset values and pipeline sizes.
 * Assumes it is included by its bare name before any user.
 */
`ifndef SDRAM_BURST_CFG_SVH
`define SDRAM_BURST_CFG_SVH

`define MODE_OFS     8'h00
`define EXT_OFS      8'h04
`define STAT_OFS     8'h08

`define LEN_LSB      0
`define BT_BIT       3
`define CLAT_LSB     4
`define WR_LSB       9
`define ALAT_LSB     3

`define LEN_CODE4    3'h2
`define LEN_CODE8    3'h3

`define MODE_RST     13'h0432
`define EXT_RST      13'h0000

`define SLOT_DEPTH   16
`define HALF_BL4     5'h02
`define HALF_BL8     5'h04
`define BEATS_BL4    4'h4
`define BEATS_BL8    4'h8
`define SLOT_BIAS    4'h2

`endif

// ===== include/sdram_burst_pkg.sv
/*
 * Types shared by the burst and precharge block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sdram_burst_pkg;
    typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE} cmd_e;
    typedef logic [15:0] word_t;
endpackage

// ===== verilog/burst_order.sv
/*
 * Column order of one burst beat from its start column and beat count.
 * Assumes beat_i counts from zero; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none
module burst_order
(
    input  wire logic [2:0] start_i,
    input  wire logic [2:0] beat_i,
    input  wire logic       bl8_i,
    input  wire logic       intlv_i,
    output logic      [2:0] col_o
);
    logic [1:0] low;
    logic       high;

    // Low bits wrap in the group of four; high bit flips only for length 8
    always_comb
    begin
        low  = intlv_i ? (start_i[1:0] ^ beat_i[1:0])
                       : (start_i[1:0] + beat_i[1:0]);
        high = bl8_i ? (start_i[2] ^ beat_i[2]) : start_i[2];
        col_o = {high, low};
    end
endmodule
`default_nettype wire

// ===== verilog/sdram_burst.sv
/*
 * Burst and precharge logic of a four-bank double-data-rate DRAM: command
 * sampling, burst ordering, read and write data timing, byte mask, bank
 * open state with explicit and automatic close, AHB-Lite mode registers.
 * Assumes the link clock and all link pins are asynchronous to sys_clk_i
 * and much slower (several system cycles per link half period).
 */
// Design decisions made here: the register offsets and the AHB-Lite slave port.
// Overview of operation
// - Only burst lengths 4 and 8 exist; other length codes are rejected.
// - Length comes from mode bits 2:0, ordering type from mode bit 3.
// - Sequential order wraps low two bits; length 8 then runs other nibble.
// - Interleaved order is start column XOR beat count, 2 or 3 bits.
// - No burst stop; only permitted interruptions cut a burst short.
// - An interrupting command may target any bank.
// - Spacing after a burst uses programmed length, not the cut length.
// - First read data appears after added plus column latency.
// - Read strobe goes low one clock early; beats follow strobe edges.
// - Write delay is added plus column latency minus one.
// - Beats beyond the programmed count are ignored.
// - One mask line per byte blocks that byte on writes, unused on reads.
// - Close all banks when auto-close bit high, else the selected bank.
// - Auto-close bit on column commands closes bank at burst tail.
// - Write auto-close starts after last beat plus recovery cycles.
`timescale 1ns/1ps
`default_nettype none
`include "sdram_burst_cfg.svh"
module sdram_burst
    import sdram_burst_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic      [31:0] hrdata_o,
    input  wire logic        ck_i,
    input  wire logic        cs_n_i,
    input  wire logic        ras_n_i,
    input  wire logic        cas_n_i,
    input  wire logic        we_n_i,
    input  wire logic [12:0] addr_i,
    input  wire logic        bank_select_bit0_i,
    input  wire logic        bank_select_bit1_i,
    input  wire logic [15:0] dq_i,
    output logic      [15:0] dq_o,
    output logic             dq_oe_o,
    input  wire logic        dqs_i,
    output logic             dqs_o,
    output logic             dqs_oe_o,
    input  wire logic [1:0]  input_byte_mask_i
);
    logic [38:0] pin_vec;
    logic [38:0] sync1_ff;
    logic [38:0] sync2_ff;
    logic        ck_d_ff;
    logic        dqs_d_ff;
    logic        ck_s, dqs_s, ck_rise, ck_fall, ck_edge;
    logic        dqs_rise, dqs_edge;
    logic [12:0] addr_s;
    logic [1:0]  ba_s, mask_s;
    word_t       dq_s;
    cmd_e        cmd;
    logic [12:0] mode_ff, ext_ff, nxt_mode;
    logic        bl8, intlv;
    logic [3:0]  column_latency, added_latency, read_delay_sum;
    logic [3:0]  store_delay_sum, wr_rec, nbeats, slot_idx;
    logic [4:0]  half_len, rd_ap_dly, wr_ap_dly;
    logic [15:0] slot_v_ff, slot_w_ff;
    logic [2:0]  slot_c_ff [0:15];
    logic        launch, launch_rd, launch_wr;
    logic        rd_arm_ff, rd_busy_ff;
    logic [2:0]  rd_next_ff, rd_col_ff, rd_seq_col;
    logic [3:0]  rd_beat_ff;
    word_t       dq_ff;
    logic        dq_oe_ff, dqs_ff, dqs_oe_ff;
    logic        wr_arm_ff, wr_go_ff, wr_pend_ff, wr_cap;
    logic [2:0]  wr_col_ff, wr_next_ff, wr_idx;
    logic [3:0]  wr_beat_ff, wr_end;
    word_t       mem_ff [0:7];
    logic [3:0]  bank_open_ff;
    logic [4:0]  ap_cnt_ff [0:3];
    logic        dph_wr_ff, dph_rd_ff, dph_hi_ff;
    logic [7:0]  dph_addr_ff;

    // Every link pin passes two flops before anything looks at it
    assign pin_vec = {ck_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, addr_i,
                      bank_select_bit1_i, bank_select_bit0_i, dq_i, dqs_i,
                      input_byte_mask_i};
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sync1_ff <= 39'h0;
            sync2_ff <= 39'h0;
            ck_d_ff  <= 1'b0;
            dqs_d_ff <= 1'b0;
        end
        else
        begin
            sync1_ff <= pin_vec;
            sync2_ff <= sync1_ff;
            ck_d_ff  <= ck_s;
            dqs_d_ff <= dqs_s;
        end
    end

    // Unpack synchronised pins and find link clock and strobe edges
    assign ck_s     = sync2_ff[38];
    assign addr_s   = sync2_ff[33:21];
    assign ba_s     = sync2_ff[20:19];
    assign dq_s     = sync2_ff[18:3];
    assign dqs_s    = sync2_ff[2];
    assign mask_s   = sync2_ff[1:0];
    assign ck_rise  = ck_s & ~ck_d_ff;
    assign ck_fall  = ~ck_s & ck_d_ff;
    assign ck_edge  = ck_rise | ck_fall;
    assign dqs_rise = dqs_s & ~dqs_d_ff;
    assign dqs_edge = dqs_s ^ dqs_d_ff;

    // Command decode; burst stop has no encoding, so it is a no-op
    always_comb
    begin
        cmd = CMD_NOP;
        if (!sync2_ff[37])
        begin
            case (sync2_ff[36:34])
                3'h3:    cmd = CMD_ACT;
                3'h5:    cmd = CMD_RD;
                3'h4:    cmd = CMD_WR;
                3'h2:    cmd = CMD_PRE;
                default: cmd = CMD_NOP;
            endcase
        end
    end

    // Mode fields and derived latencies; timings use programmed length
    assign bl8     = mode_ff[`LEN_LSB +: 3] == `LEN_CODE8;
    assign intlv   = mode_ff[`BT_BIT];
    assign column_latency = {1'b0, mode_ff[`CLAT_LSB +: 3]};
    assign added_latency  = {1'b0, ext_ff[`ALAT_LSB +: 3]};
    assign wr_rec  = {1'b0, mode_ff[`WR_LSB +: 3]} + 4'h1;
    assign read_delay_sum  = added_latency + column_latency;
    assign store_delay_sum = read_delay_sum - 4'h1;
    assign nbeats  = bl8 ? `BEATS_BL8 : `BEATS_BL4;
    assign half_len = bl8 ? `HALF_BL8 : `HALF_BL4;
    assign rd_ap_dly = {1'b0, added_latency} + half_len;
    assign wr_ap_dly = {1'b0, store_delay_sum} + half_len
                     + {1'b0, wr_rec};
    assign slot_idx  = ((cmd == CMD_RD) ? read_delay_sum : store_delay_sum)
                     - `SLOT_BIAS;

    // Latency line: a column command launches one link clock before data
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            slot_v_ff <= 16'h0;
            slot_w_ff <= 16'h0;
            for (int i = 0; i < `SLOT_DEPTH; i++)
            begin
                slot_c_ff[i] <= 3'h0;
            end
        end
        else if (ck_rise)
        begin
            slot_v_ff <= {1'b0, slot_v_ff[15:1]};
            slot_w_ff <= {1'b0, slot_w_ff[15:1]};
            for (int i = 0; i < `SLOT_DEPTH - 1; i++)
            begin
                slot_c_ff[i] <= slot_c_ff[i+1];
            end
            slot_c_ff[15] <= 3'h0;
            // Any bank may interrupt; storage ignores the bank
            if (cmd == CMD_RD || cmd == CMD_WR)
            begin
                slot_v_ff[slot_idx] <= 1'b1;
                slot_w_ff[slot_idx] <= cmd == CMD_WR;
                slot_c_ff[slot_idx] <= addr_s[2:0];
            end
        end
    end
    assign launch    = ck_rise & slot_v_ff[0];
    assign launch_rd = launch & ~slot_w_ff[0];
    assign launch_wr = launch & slot_w_ff[0];

    burst_order u_rd_order
    (
        .start_i (rd_col_ff),
        .beat_i  (rd_beat_ff[2:0]),
        .bl8_i   (bl8),
        .intlv_i (intlv),
        .col_o   (rd_seq_col)
    );

    burst_order u_wr_order
    (
        .start_i (wr_col_ff),
        .beat_i  (wr_beat_ff[2:0]),
        .bl8_i   (bl8),
        .intlv_i (intlv),
        .col_o   (wr_idx)
    );

    // Read output: preamble, then one beat per link clock edge
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rd_arm_ff  <= 1'b0;
            rd_busy_ff <= 1'b0;
            rd_next_ff <= 3'h0;
            rd_col_ff  <= 3'h0;
            rd_beat_ff <= 4'h0;
            dq_ff      <= 16'h0;
            dq_oe_ff   <= 1'b0;
            dqs_ff     <= 1'b0;
            dqs_oe_ff  <= 1'b0;
        end
        else
        begin
            // A pending burst takes over at its rise, cutting the old one
            if (ck_rise && rd_arm_ff)
            begin
                rd_arm_ff  <= 1'b0;
                rd_busy_ff <= 1'b1;
                rd_col_ff  <= rd_next_ff;
                rd_beat_ff <= 4'h1;
                dq_ff      <= mem_ff[rd_next_ff];
                dq_oe_ff   <= 1'b1;
                dqs_ff     <= 1'b1;
                dqs_oe_ff  <= 1'b1;
            end
            else if (ck_edge && rd_busy_ff)
            begin
                if (rd_beat_ff == nbeats)
                begin
                    rd_busy_ff <= 1'b0;
                    dq_oe_ff   <= 1'b0;
                    dqs_ff     <= 1'b0;
                    dqs_oe_ff  <= launch_rd;
                end
                else
                begin
                    dq_ff      <= mem_ff[rd_seq_col];
                    rd_beat_ff <= rd_beat_ff + 4'h1;
                    dqs_ff     <= ~dqs_ff;
                end
            end
            if (launch_rd)
            begin
                rd_arm_ff  <= 1'b1;
                rd_next_ff <= slot_c_ff[0];
                // Strobe low one clock before data when the bus was idle
                if (!rd_busy_ff)
                begin
                    dqs_oe_ff <= 1'b1;
                    dqs_ff    <= 1'b0;
                end
            end
        end
    end
    assign dq_o     = dq_ff;
    assign dq_oe_o  = dq_oe_ff;
    assign dqs_o    = dqs_ff;
    assign dqs_oe_o = dqs_oe_ff;

    // Write capture: a cut burst ends after four beats, then the next runs
    assign wr_end = wr_pend_ff ? `BEATS_BL4 : nbeats;
    assign wr_cap = wr_arm_ff & (wr_go_ff ? dqs_edge : dqs_rise);
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_arm_ff  <= 1'b0;
            wr_go_ff   <= 1'b0;
            wr_pend_ff <= 1'b0;
            wr_col_ff  <= 3'h0;
            wr_next_ff <= 3'h0;
            wr_beat_ff <= 4'h0;
        end
        else
        begin
            if (wr_cap)
            begin
                if (wr_beat_ff + 4'h1 == wr_end)
                begin
                    // Later strobe edges find the capture disarmed unless a cut-in write is pending
                    wr_arm_ff  <= wr_pend_ff;
                    wr_go_ff   <= 1'b0;
                    wr_pend_ff <= 1'b0;
                    wr_col_ff  <= wr_next_ff;
                    wr_beat_ff <= 4'h0;
                end
                else
                begin
                    wr_beat_ff <= wr_beat_ff + 4'h1;
                    wr_go_ff   <= 1'b1;
                end
            end
            if (launch_wr)
            begin
                if (wr_arm_ff && wr_go_ff)
                begin
                    wr_pend_ff <= 1'b1;
                    wr_next_ff <= slot_c_ff[0];
                end
                else
                begin
                    wr_arm_ff  <= 1'b1;
                    wr_go_ff   <= 1'b0;
                    wr_col_ff  <= slot_c_ff[0];
                    wr_beat_ff <= 4'h0;
                end
            end
        end
    end

    // Tiny data store indexed by the low column bits; masked bytes kept
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < 8; i++)
            begin
                mem_ff[i] <= 16'h0;
            end
        end
        else if (wr_cap)
        begin
            for (int b = 0; b < 2; b++)
            begin
                if (!mask_s[b])
                begin
                    mem_ff[wr_idx][8*b +: 8] <= dq_s[8*b +: 8];
                end
            end
        end
    end

    // Bank state: activate opens, close and auto-close shut
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            bank_open_ff <= 4'h0;
            for (int b = 0; b < 4; b++)
            begin
                ap_cnt_ff[b] <= 5'h0;
            end
        end
        else if (ck_rise)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (ap_cnt_ff[b] != 5'h0)
                begin
                    ap_cnt_ff[b] <= ap_cnt_ff[b] - 5'h1;
                    if (ap_cnt_ff[b] == 5'h1)
                    begin
                        bank_open_ff[b] <= 1'b0;
                    end
                end
            end
            case (cmd)
                CMD_ACT: bank_open_ff[ba_s] <= 1'b1;
                CMD_PRE:
                begin
                    if (addr_s[10])
                    begin
                        bank_open_ff <= 4'h0;
                    end
                    else
                    begin
                        bank_open_ff[ba_s] <= 1'b0;
                    end
                end
                CMD_RD:
                begin
                    if (addr_s[10])
                    begin
                        ap_cnt_ff[ba_s] <= rd_ap_dly;
                    end
                end
                CMD_WR:
                begin
                    if (addr_s[10])
                    begin
                        ap_cnt_ff[ba_s] <= wr_ap_dly;
                    end
                end
                default: ;
            endcase
        end
    end

    // AHB-Lite: zero wait states, always OKAY, writes land in data phase
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            dph_wr_ff   <= 1'b0;
            dph_rd_ff   <= 1'b0;
            dph_hi_ff   <= 1'b0;
            dph_addr_ff <= 8'h0;
        end
        else if (hready_i)
        begin
            dph_wr_ff   <= hsel_i & htrans_i[1] & hwrite_i;
            dph_rd_ff   <= hsel_i & htrans_i[1] & ~hwrite_i;
            dph_hi_ff   <= |haddr_i[31:8];
            dph_addr_ff <= haddr_i[7:0];
        end
    end

    // An illegal length code leaves the previous length in place
    always_comb
    begin
        nxt_mode = hwdata_i[12:0];
        if (hwdata_i[2:0] != `LEN_CODE4 && hwdata_i[2:0] != `LEN_CODE8)
        begin
            nxt_mode[`LEN_LSB +: 3] = mode_ff[`LEN_LSB +: 3];
        end
    end

    // Mode words; changing them during a burst is not protected
    always_ff @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            mode_ff <= `MODE_RST;
            ext_ff  <= `EXT_RST;
        end
        else if (dph_wr_ff && !dph_hi_ff)
        begin
            if (dph_addr_ff == `MODE_OFS)
            begin
                mode_ff <= nxt_mode;
            end
            if (dph_addr_ff == `EXT_OFS)
            begin
                ext_ff <= hwdata_i[12:0];
            end
        end
    end

    // Read mux from flops; unmapped addresses read zero
    always_comb
    begin
        hrdata_o = 32'h0;
        if (dph_rd_ff && !dph_hi_ff)
        begin
            case (dph_addr_ff)
                `MODE_OFS: hrdata_o = {19'h0, mode_ff};
                `EXT_OFS:  hrdata_o = {19'h0, ext_ff};
                `STAT_OFS: hrdata_o = {26'h0, wr_arm_ff, rd_busy_ff,
                                       bank_open_ff};
                default:   hrdata_o = 32'h0;
            endcase
        end
    end
    assign hreadyout_o = 1'b1;
    assign hresp_o     = 1'b0;

    default clocking dc @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    AST_LEN_LEGAL: assert property (mode_ff[2:0] == `LEN_CODE4 ||
        mode_ff[2:0] == `LEN_CODE8) else $error("Illegal burst length");
    AST_SEQ_ORDER: assert property (!intlv && rd_busy_ff |->
        rd_seq_col[1:0] == rd_col_ff[1:0] + rd_beat_ff[1:0])
        else $error("Sequential order wrong");
    AST_INTLV_ORDER: assert property (intlv && bl8 |->
        rd_seq_col == (rd_col_ff ^ rd_beat_ff[2:0]))
        else $error("Interleaved order wrong");
    AST_RD_SLOT: assert property (ck_rise && cmd == CMD_RD |=>
        slot_v_ff[$past(slot_idx)] && !slot_w_ff[$past(slot_idx)])
        else $error("Read not scheduled at read delay");
    AST_WR_SLOT: assert property (ck_rise && cmd == CMD_WR |=>
        slot_w_ff[$past(slot_idx)] &&
        $past(slot_idx) == $past(store_delay_sum) - 4'h2)
        else $error("Write not scheduled at write delay");
    AST_PREAMBLE: assert property ($rose(dqs_oe_o) |->
        !dqs_o && !dq_oe_o) else $error("No strobe preamble");
    AST_FIRST_BEAT: assert property ($rose(dq_oe_o) |->
        dqs_o && $past(dqs_oe_o) && !$past(dqs_o))
        else $error("First beat not on strobe rise");
    AST_WR_LIMIT: assert property (wr_cap |-> wr_beat_ff < nbeats)
        else $error("Write beat beyond burst");
    AST_MASK: assert property (wr_cap && mask_s[0] |=>
        mem_ff[$past(wr_idx)][7:0] == $past(mem_ff[wr_idx][7:0]))
        else $error("Masked byte hit");
    AST_PRE_ALL: assert property (ck_rise && cmd == CMD_PRE &&
        addr_s[10] |=> bank_open_ff == 4'h0) else $error("Close all failed");
    AST_ACT_OPEN: assert property (ck_rise && cmd == CMD_ACT |=>
        bank_open_ff[$past(ba_s)]) else $error("Activate did not open");
    AST_AP_LOAD: assert property (ck_rise && cmd == CMD_RD &&
        addr_s[10] |=> ap_cnt_ff[$past(ba_s)] == $past(rd_ap_dly))
        else $error("Auto-close delay wrong");

    COV_READ: cover property (launch_rd ##[1:300] $fell(dq_oe_o));
    COV_RD_CUT: cover property (launch_rd && rd_busy_ff);
    COV_WR_FULL: cover property (wr_cap && wr_beat_ff == 4'h7);
    COV_PRE_ALL: cover property (ck_rise && cmd == CMD_PRE && addr_s[10]);
endmodule
`default_nettype wire

// ===== dv/ctrl_model.sv
/* Controller model: free link clock, commands and write bursts.
   Assumes the device samples its pins on the link clock rise. */
`timescale 1ns/1ps
`default_nettype none
module ctrl_model
(
    output logic        ck_o,
    output logic [3:0]  cmd_n_o,
    output logic [12:0] addr_o,
    output logic [1:0]  ba_o,
    output logic [15:0] dq_o,
    output logic        dqs_o,
    output logic [1:0]  mask_o
);
    // Link clock runs free, the device needs it between bursts
    initial
    begin
        ck_o = 1'b0;
        forever #80 ck_o = ~ck_o;
    end
    initial
    begin
        cmd_n_o = 4'hf;
        addr_o = 13'h0000;
        ba_o = 2'h0;
        dq_o = 16'h0000;
        dqs_o = 1'b0;
        mask_o = 2'h0;
    end
    // Pins move on the fall so they stand still at the rise
    task automatic cmd(input logic [2:0] rcw, input logic [12:0] a,
                       input logic [1:0] b);
        @(negedge ck_o);
        cmd_n_o = {1'b0, rcw};
        addr_o = a;
        ba_o = b;
        @(negedge ck_o);
        cmd_n_o = 4'h7;
        addr_o = ~a;
    endtask
    // Beats straddle each strobe edge by a quarter period; last two are junk
    task automatic wr(input int dly, input int n, input logic [15:0] base,
                      input int mb);
        #(160 * dly - 120);
        for (int k = 0; k < n; k++)
        begin
            dq_o = (k < n - 2) ? base + 16'h0101 * k[15:0] : 16'hdead;
            mask_o = (k == mb) ? 2'h1 : 2'h0;
            #40 dqs_o = ~dqs_o;
            #40;
        end
        dq_o = ~dq_o;
        mask_o = 2'h3;
    endtask
endmodule
`default_nettype wire

// ===== dv/sdram_burst_precharge_logic_bench.sv
/* Bench: registers, write and read bursts, bank state.
   Assumes the controller model ctrl_model on the link side. */
`timescale 1ns/1ps
`default_nettype none
module sdram_burst_precharge_logic_bench;
    logic        sys_clk_i;
    logic        rst_n_i;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [1:0]  htrans;
    logic        hwrite;
    logic        hready;
    logic        ck;
    logic [3:0]  pins;
    logic [12:0] addr;
    logic [1:0]  ba;
    logic [1:0]  mask;
    logic [15:0] dq_w;
    logic [15:0] dq_r;
    logic        dqs_w;
    logic        dqs_r;
    logic        dq_oe;
    logic        dqs_oe;
    logic [15:0] ref_mem [8];
    int          miscompares = 0;
    int          n_compared = 0;
    int          cyc = 0;
    sdram_burst uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .hsel_i(1'b1),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hreadyout_o(hready), .hresp_o(), .hrdata_o(hrdata), .ck_i(ck),
        .cs_n_i(pins[3]), .ras_n_i(pins[2]), .cas_n_i(pins[1]),
        .we_n_i(pins[0]), .addr_i(addr), .bank_select_bit0_i(ba[0]),
        .bank_select_bit1_i(ba[1]), .dq_i(dq_w), .dq_o(dq_r),
        .dq_oe_o(dq_oe), .dqs_i(dqs_w), .dqs_o(dqs_r), .dqs_oe_o(dqs_oe),
        .input_byte_mask_i(mask));
    ctrl_model ctl (.ck_o(ck), .cmd_n_o(pins), .addr_o(addr), .ba_o(ba),
        .dq_o(dq_w), .dqs_o(dqs_w), .mask_o(mask));
    initial
    begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    // Cuts a hang short; the run needs far fewer cycles
    always @(posedge sys_clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input string nm, input logic [15:0] seen, exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One single word transfer, held until hready is seen high
    task automatic ahb(input logic w, input logic [31:0] a, d,
                       output logic [31:0] r);
        @(posedge sys_clk_i);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge sys_clk_i); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge sys_clk_i); while (hready !== 1'b1);
        r = hrdata;
    endtask
    // Column order tables hold one hex digit per beat, first beat leftmost
    task automatic burst_wr(input logic [2:0] col, input int n,
                            input logic [15:0] base, input logic [31:0] tbl);
        logic [2:0] c;
        logic [15:0] v;
        ctl.cmd(3'b100, {10'h000, col}, 2'h0);
        ctl.wr(2, n + 2, base, 1);
        for (int k = 0; k < n; k++)
        begin
            c = tbl[4 * (n - 1 - k) +: 3];
            v = base + 16'h0101 * k[15:0];
            // Masked low byte of beat 1 keeps what the store held
            ref_mem[c] = (k == 1) ? {v[15:8], ref_mem[c][7:0]} : v;
        end
    endtask
    task automatic burst_rd(input logic [2:0] col, input int n,
                            input logic [31:0] tbl);
        logic p;
        ctl.cmd(3'b101, {10'h000, col}, 2'h0);
        while (dqs_oe !== 1'b1)
            @(negedge sys_clk_i);
        check("preamble", {dq_oe, dqs_r}, 16'h0000);
        for (int k = 0; k < n; k++)
        begin
            p = dqs_r;
            while (dqs_r === p)
                @(negedge sys_clk_i);
            check("beat", dq_r, ref_mem[tbl[4 * (n - 1 - k) +: 3]]);
        end
        #400;
        check("burst end", {dqs_oe, dq_oe}, 16'h0000);
    endtask
    task automatic stat(input logic [3:0] exp);
        logic [31:0] r;
        #400;
        ahb(1'b0, 32'h8, 32'h0, r);
        check("bank state", r[15:0], {12'h000, exp});
    endtask
    task automatic t_regs();
        logic [31:0] r;
        ahb(1'b0, 32'h0, 32'h0, r);
        check("mode reset", r[15:0], 16'h0432);
        ahb(1'b1, 32'hc, 32'hffffffff, r);
        ahb(1'b0, 32'hc, 32'h0, r);
        check("unmapped", r[15:0], 16'h0000);
    endtask
    // Length 4: sequential write with spare beats, then both read orders
    task automatic t_len4();
        logic [31:0] r;
        ctl.cmd(3'b011, 13'h0000, 2'h0);
        burst_wr(3'h1, 4, 16'h5a30, 32'h1230);
        burst_rd(3'h1, 4, 32'h1230);
        ahb(1'b1, 32'h0, 32'h043a, r);
        burst_rd(3'h3, 4, 32'h3210);
    endtask
    // Length 8; an unknown length code must keep length 8
    task automatic t_len8();
        logic [31:0] r;
        ahb(1'b1, 32'h0, 32'h0433, r);
        burst_wr(3'h5, 8, 16'hc040, 32'h56741230);
        ahb(1'b1, 32'h0, 32'h043d, r);
        burst_rd(3'h5, 8, 32'h54761032);
    endtask
    task automatic t_banks();
        ctl.cmd(3'b010, 13'h0400, 2'h0);
        stat(4'h0);
        ctl.cmd(3'b011, 13'h0000, 2'h1);
        ctl.cmd(3'b011, 13'h0000, 2'h2);
        stat(4'h6);
        ctl.cmd(3'b010, 13'h0000, 2'h1);
        ctl.cmd(3'b011, 13'h0000, 2'h3);
        stat(4'hc);
        ctl.cmd(3'b101, 13'h0400, 2'h3);
        #3200;
        stat(4'h4);
        ctl.cmd(3'b100, 13'h0400, 2'h2);
        ctl.wr(2, 10, 16'h0000, 9);
        #1600;
        stat(4'h0);
        ctl.cmd(3'b010, 13'h0400, 2'h0);
        stat(4'h0);
    endtask
    initial
    begin
        rst_n_i = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        ref_mem = '{default: 16'h0000};
        repeat (5) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge sys_clk_i);
        t_regs();
        t_len4();
        t_len8();
        t_banks();
        give_verdict();
    end
endmodule
`default_nettype wire
